// ---- bench/cfar_far_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// one downstream far side: latency from key[4:2], so both prompt and slow answers occur
module cfar_far_model (
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic        valid,
  input  wire logic [31:0] key,
  input  wire logic        t0,
  output logic             done,
  output logic [31:0]      rdata,
  output logic             mabort
);
  logic [2:0] cnt_r;
  logic       fire;
  assign fire = valid && !done && cnt_r == key[4:2];
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r  <= 3'h0;
      done   <= 1'b0;
      rdata  <= 32'h0;
      mabort <= 1'b0;
    end else begin
      cnt_r  <= (valid && !done) ? cnt_r + 3'h1 : 3'h0;
      done   <= fire;
      // released data toggles so a stale value never matches
      rdata  <= fire ? ~key : ~rdata;
      // type 0 with no select line finds no target
      mabort <= fire && t0 && key[31:16] == 16'h0;
    end
  end
endmodule
`default_nettype wire

// ---- bench/cfar_router_assertions.sv ----
`timescale 1ns/10ps
`default_nettype none
module cfar_router_assertions (
  input wire logic                ref_clk,
  input wire logic                arst_n,
  input wire logic                host_busy,
  input wire logic                host_done,
  input wire logic [31:0]         host_rdata,
  input wire logic [7:0]          downstream_bus_id,
  input wire logic [7:0]          last_bus_id,
  input wire logic                hub_valid,
  input wire cfar_pkg::cfar_cyc_s hub_cyc,
  input wire logic                hub_done,
  input wire logic                gp_valid,
  input wire cfar_pkg::cfar_cyc_s gp_cyc,
  input wire logic                gp_done,
  input wire logic                gp_mabort,
  input wire logic                bridge_mabort,
  input wire logic                int_valid,
  input wire logic                config_access_enable
);
  import cfar_pkg::*;
  logic [7:0] hbus;
  logic [7:0] gbus;
  assign hbus = hub_cyc.addr[23:16];
  assign gbus = gp_cyc.addr[23:16];
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  a_no_cfg_off:
    assert property (($rose(hub_valid) && hub_cyc.kind != CFAR_CYC_IO) || $rose(gp_valid)
      || $rose(int_valid) |-> config_access_enable) else $error("config cycle while disabled");
  a_gp_one_idsel:
    assert property (gp_valid && gp_cyc.kind == CFAR_CYC_CFG0 |-> $onehot0(gp_cyc.addr[31:16]))
      else $error("more than one select line");
  a_gp_type_range:
    assert property (gp_valid |-> (gp_cyc.kind == CFAR_CYC_CFG0 && gp_cyc.addr[1:0] == 2'h0)
      || (gp_cyc.kind == CFAR_CYC_CFG1 && gp_cyc.addr[1:0] == 2'h1 && gbus > downstream_bus_id
      && gbus <= last_bus_id)) else $error("bad graphics-port cycle type");
  a_hub_t0_dev:
    assert property (hub_valid && hub_cyc.kind == CFAR_CYC_CFG0 |-> hub_cyc.addr[31:16] == 16'h0
      && hub_cyc.addr[15:11] > CFAR_INT_DEV_LAST) else $error("bad hub type 0 cycle");
  a_hub_t1_range:
    assert property (hub_valid && hub_cyc.kind == CFAR_CYC_CFG1 |-> hbus != 8'h0
      && hbus != downstream_bus_id && !(hbus > downstream_bus_id && hbus <= last_bus_id))
      else $error("hub type 1 for a graphics-port bus");
  a_one_down:
    assert property ($onehot0({hub_valid, gp_valid, int_valid}))
      else $error("two downstream cycles at once");
  a_hub_hold:
    assert property (hub_valid && !hub_done |=> hub_valid && $stable(hub_cyc))
      else $error("hub cycle changed before done");
  a_hub_answer:
    assert property (hub_valid && hub_done |=> host_done && !hub_valid)
      else $error("hub completion not answered");
  a_gp_abort:
    assert property (gp_valid && gp_done && gp_mabort && !gp_cyc.wr |=> bridge_mabort
      && host_rdata == CFAR_ABORT_DATA) else $error("abort not recorded");
  a_busy_track:
    assert property (host_busy == (hub_valid || gp_valid || int_valid))
      else $error("busy does not follow the downstream cycle");
  c_gp_abort: cover property (gp_valid && gp_done && gp_mabort);
  c_hub_t1: cover property (hub_valid && hub_cyc.kind == CFAR_CYC_CFG1);
  c_int: cover property ($fell(int_valid));
endmodule
bind cfar_router cfar_router_assertions cfar_router_assertions_inst (.*);
`default_nettype wire

// ---- bench/test_config_access_router.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, x) begin check_count++; if ((g) !== (x)) begin fail_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (x)); end end
module test_config_access_router;
  import cfar_pkg::*;
  typedef struct packed {
    logic [1:0]  path;
    logic [31:0] addr;
    logic [31:0] rd;
  } cfar_exp_s;
  logic        ref_clk, arst_n, host_valid, host_busy, host_done, bridge_mabort;
  logic        hub_valid, hub_done, hub_mabort, gp_valid, gp_done, gp_mabort;
  logic        int_valid, int_done, config_access_enable;
  logic [31:0] host_rdata, hub_rdata, gp_rdata, int_rdata, ptr, paddr, r;
  logic [7:0]  downstream_bus_id, last_bus_id, b;
  logic [1:0]  path;
  logic [36:0] pcmd;
  cfar_io_s    host_req;
  cfar_cyc_s   hub_cyc, gp_cyc;
  cfar_int_s   int_req;
  int          fail_count, check_count;
  logic [3:0]  bes [5] = '{4'hF, 4'h1, 4'h3, 4'hC, 4'h8};

  cfar_router cfar_router_inst (.*);
  cfar_far_model hub_model (.ref_clk, .arst_n, .valid(hub_valid), .key(hub_cyc.addr),
    .t0(1'b0), .done(hub_done), .rdata(hub_rdata), .mabort(hub_mabort));
  cfar_far_model gp_model (.ref_clk, .arst_n, .valid(gp_valid), .key(gp_cyc.addr),
    .t0(gp_cyc.kind == CFAR_CYC_CFG0), .done(gp_done), .rdata(gp_rdata), .mabort(gp_mabort));
  cfar_far_model int_model (.ref_clk, .arst_n, .valid(int_valid),
    .key({24'h0, int_req.dev, int_req.regn}), .t0(1'b0), .done(int_done), .rdata(int_rdata),
    .mabort());

  function automatic cfar_exp_s expect_cyc(input logic [15:0] a, input logic [3:0] be);
    cfar_exp_s  e;
    logic [7:0] bn;
    logic [4:0] d;
    bn = ptr[23:16];
    d  = ptr[15:11];
    e  = '{2'h1, {16'h0, a}, 32'h0};
    if (a[15:2] == 14'h33E && be == 4'hF) e = '{2'h0, 32'h0, ptr};
    else if (a[15:2] == 14'h33F && ptr[31]) begin
      e.addr = {8'h0, ptr[23:2], 2'h1};
      if (bn == 8'h0) e.addr = {16'h0, ptr[15:2], 2'h0};
      if (bn == 8'h0 && d <= 5'h2) begin
        e.path = ptr[10:8] == 3'h0 ? 2'h3 : 2'h0;
        e.addr = {24'h0, d[1:0], ptr[7:2]};
        e.rd   = CFAR_ABORT_DATA;
      end
      if (bn != 8'h0 && bn == downstream_bus_id) begin
        e.path = 2'h2;
        e.addr = {d <= 5'hF ? 16'h1 << d : 16'h0, 5'h0, ptr[10:2], 2'h0};
      end
      if (bn != 8'h0 && bn > downstream_bus_id && bn <= last_bus_id) e.path = 2'h2;
    end
    if (e.path != 2'h0) e.rd = (e.path == 2'h2 && e.addr[31:16] == 16'h0 && !e.addr[0]) ?
      CFAR_ABORT_DATA : ~e.addr;
    return e;
  endfunction

  task automatic io(input logic w, input logic [15:0] a, input logic [3:0] be,
                    input logic [31:0] wd);
    cfar_exp_s e;
    int        n;
    host_valid <= 1'b1;
    host_req   <= '{w, a, be, wd};
    @(posedge ref_clk);
    host_valid <= 1'b0;
    path = 2'h0;
    e    = expect_cyc(a, be);
    n    = 0;
    do begin
      @(posedge ref_clk);
      n++;
      // path codes: 1 hub, 2 graphics port, 3 internal
      if (path == 2'h0 && (hub_valid | gp_valid | int_valid) === 1'b1) begin
        path  = {gp_valid | int_valid, hub_valid | int_valid};
        paddr = hub_valid ? hub_cyc.addr : gp_valid ? gp_cyc.addr :
          {24'h0, int_req.dev, int_req.regn};
        pcmd  = hub_valid ? {hub_cyc.wr, hub_cyc.be, hub_cyc.wdata} : gp_valid ?
          {gp_cyc.wr, gp_cyc.be, gp_cyc.wdata} : {int_req.wr, int_req.be, int_req.wdata};
      end
    end while (host_done !== 1'b1 && n < 40);
    `CHK(n < 40, 1'b1)
    `CHK(path, e.path)
    if (e.path != 2'h0) `CHK(paddr, e.addr)
    if (e.path != 2'h0) `CHK(pcmd, {w, be, wd})
    if (!w) `CHK(host_rdata, e.rd)
    if (w && a[15:2] == 14'h33E && be == 4'hF) ptr = wd & CFAR_PTR_WMASK;
    `CHK(config_access_enable, ptr[31])
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial begin
    #400_000;
    fail_count++;
    end_sim;
  end

  initial begin
    arst_n            = 1'b0;
    host_valid        = 1'b0;
    host_req          = '0;
    downstream_bus_id = 8'h05;
    last_bus_id       = 8'h09;
    ptr               = CFAR_PTR_RESET;
    path              = 2'h0;
    paddr             = 32'h0;
    fail_count        = 0;
    check_count       = 0;
    r                 = $urandom(33);
    repeat (6) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    io(1'b0, 16'h0CF8, 4'hF, 32'h0);
    io(1'b1, 16'h0CFC, 4'hF, 32'h1234);
    io(1'b1, 16'h0CF8, 4'h3, 32'hFFFF);
    repeat (400) begin
      r = $urandom;
      case (r[12:10])
        3'h0, 3'h1: b = 8'h00;
        3'h2: b = downstream_bus_id;
        3'h3: b = downstream_bus_id + 8'h1;
        3'h4: b = last_bus_id;
        3'h5: b = last_bus_id + 8'h1;
        default: b = r[7:0];
      endcase
      io(1'b1, 16'h0CF8, 4'hF, {r[0] | r[1], 7'h7F, b, r[16] ? {2'h0, r[15:13]} : r[21:17],
         r[31:30] == 2'h0 ? r[24:22] : 3'h0, r[30:25], 2'h3});
      r = $urandom;
      io(r[0], r[2:1] == 2'h3 ? {4'h1, r[31:20]} : {12'h0CF, r[2] | r[1] ? 4'hC : 4'h8},
         bes[r[6:4] % 5], $urandom);
      if (r[9:7] == 3'h0) {downstream_bus_id, last_bus_id} <= {4'h0, r[13:10], 4'h0, r[17:14]};
      if (r[19:18] == 2'h0) io(1'b0, 16'h0CF8, 4'hF, 32'h0);
    end
    end_sim;
  end
endmodule
`default_nettype wire

// ---- hdl/cfar_decode.sv ----
`timescale 1ns/10ps
`default_nettype none
module cfar_decode (
  input  wire logic [31:0]         ptr,
  input  wire logic [7:0]          sec_bus,
  input  wire logic [7:0]          sub_bus,
  output cfar_pkg::cfar_route_e    route,
  output cfar_pkg::cfar_kind_e     kind,
  output logic [31:0]              cyc_addr
);
  import cfar_pkg::*;

  logic [7:0] bus;
  logic [4:0] dev;
  logic [2:0] fn;
  logic [5:0] regn;
  logic [31:0] idsel;

  always_comb begin
    bus  = cfar_bus(ptr);
    dev  = cfar_dev(ptr);
    fn   = cfar_fn(ptr);
    regn = cfar_reg(ptr);
    idsel = '0;
    if (dev <= CFAR_IDSEL_MAX) begin
      idsel[CFAR_IDSEL_BASE + int'(dev)] = 1'b1;
    end
  end

  always_comb begin
    route    = CFAR_RT_HUB;
    kind     = CFAR_CYC_CFG0;
    cyc_addr = {16'h0000, dev, fn, regn, CFAR_TYPE0_LOW};
    if (bus == CFAR_BUS_ZERO) begin
      if (dev <= CFAR_INT_DEV_LAST) begin
        route = (fn == CFAR_FN_ONLY) ? CFAR_RT_INTERNAL : CFAR_RT_INT_ABORT;
      end
    end else if (bus == sec_bus) begin
      route    = CFAR_RT_GP;
      cyc_addr = idsel | {21'h000000, fn, regn, CFAR_TYPE0_LOW};
    end else if (bus > sec_bus && bus <= sub_bus) begin
      route    = CFAR_RT_GP;
      kind     = CFAR_CYC_CFG1;
      cyc_addr = {8'h00, bus, dev, fn, regn, CFAR_TYPE1_LOW};
    end else begin
      kind     = CFAR_CYC_CFG1;
      cyc_addr = {8'h00, bus, dev, fn, regn, CFAR_TYPE1_LOW};
    end
  end

endmodule
`default_nettype wire

// ---- hdl/cfar_pkg.sv ----
// Behaviour
// - non-zero bus equal to downstream_bus_id gives graphics-port Type 0 cycle
// - Type 0 graphics-port cycle to devices 0..15 drives one IDSEL line, device n on line 16+n
// - device above 15: Type 0 cycle without IDSEL, master abort recorded in bridge
// - hub link configuration cycles carry device number on address bits 15:11
// - graphics-port Type 1 cycles carry device number on bits 15:11
// - function number drives address/data bits 10:8 of every hub link and graphics-port configuration cycle
// - bus 0 devices 0..2 accept function 000b only, others master abort
// - pointer bits 7:2 pick the dword register, bits 1:0 reserved
// - with enable set, data window I/O accesses map into configuration space
// - only the pointer plus data window mechanism exists
// - no configuration cycle while pointer enable bit is clear
// - with enable set, every data window read or write becomes the matching configuration cycle, except bus 0 devices 0..2 with function other than 000b
// - pointer bits 23:16 are the bus number, zero means logical bus 0
// - bus 0: device 0 host bridge, 1 graphics bridge, 2 graphics unit
// - cycles to internal devices 0..2 complete inside, never reach hub
// - bus 0 devices 3..31 are forwarded over the hub link
// - non-zero bus outside graphics-port range goes to hub as configuration cycle
// - bus above downstream_bus_id and up to last_bus_id gives graphics-port Type 1
// - pointer captured on dword access only, partial accesses pass downstream as I/O
package cfar_pkg;

  localparam logic [15:0] CFAR_PTR_IO_ADDR  = 16'h0CF8;
  localparam logic [15:0] CFAR_DATA_IO_ADDR = 16'h0CFC;
  localparam logic [31:0] CFAR_PTR_RESET    = 32'h00000000;
  localparam logic [31:0] CFAR_PTR_WMASK    = 32'h80FFFFFC;
  localparam logic [31:0] CFAR_ABORT_DATA   = 32'hFFFFFFFF;
  localparam logic [3:0]  CFAR_BE_DWORD     = 4'hF;
  localparam int          CFAR_EN_BIT       = 31;
  localparam int          CFAR_BUS_LSB      = 16;
  localparam int          CFAR_DEV_LSB      = 11;
  localparam int          CFAR_FN_LSB       = 8;
  localparam int          CFAR_REG_LSB      = 2;
  localparam int          CFAR_IDSEL_BASE   = 16;
  localparam logic [4:0]  CFAR_IDSEL_MAX    = 5'h0F;
  localparam logic [4:0]  CFAR_INT_DEV_LAST = 5'h02;
  localparam logic [2:0]  CFAR_FN_ONLY      = 3'h0;
  localparam logic [7:0]  CFAR_BUS_ZERO     = 8'h00;
  localparam logic [1:0]  CFAR_TYPE0_LOW    = 2'h0;
  localparam logic [1:0]  CFAR_TYPE1_LOW    = 2'h1;

  typedef enum logic [1:0] {
    CFAR_CYC_IO,
    CFAR_CYC_CFG0,
    CFAR_CYC_CFG1
  } cfar_kind_e;

  typedef enum logic [1:0] {
    CFAR_RT_INTERNAL,
    CFAR_RT_INT_ABORT,
    CFAR_RT_GP,
    CFAR_RT_HUB
  } cfar_route_e;

  typedef struct packed {
    logic        wr;
    logic [15:0] addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } cfar_io_s;

  typedef struct packed {
    logic        wr;
    cfar_kind_e  kind;
    logic [31:0] addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } cfar_cyc_s;

  typedef struct packed {
    logic        wr;
    logic [1:0]  dev;
    logic [5:0]  regn;
    logic [3:0]  be;
    logic [31:0] wdata;
  } cfar_int_s;

  function automatic logic [7:0] cfar_bus(input logic [31:0] p);
    return p[CFAR_BUS_LSB +: 8];
  endfunction

  function automatic logic [4:0] cfar_dev(input logic [31:0] p);
    return p[CFAR_DEV_LSB +: 5];
  endfunction

  function automatic logic [2:0] cfar_fn(input logic [31:0] p);
    return p[CFAR_FN_LSB +: 3];
  endfunction

  function automatic logic [5:0] cfar_reg(input logic [31:0] p);
    return p[CFAR_REG_LSB +: 6];
  endfunction

  function automatic logic [13:0] cfar_io_word(input logic [15:0] a);
    return a[15:2];
  endfunction

endpackage

// ---- hdl/cfar_router.sv ----
`timescale 1ns/10ps
`default_nettype none
// single mechanism: pointer at one I/O dword, data window at the next
module cfar_router (
  input  wire logic                ref_clk,
  input  wire logic                arst_n,
  // host processor I/O cycles
  input  wire logic                host_valid,
  input  wire cfar_pkg::cfar_io_s  host_req,
  output logic                     host_busy,
  output logic                     host_done,
  output logic [31:0]              host_rdata,
  // bridge bus range from the graphics-port bridge registers
  input  wire logic [7:0]          downstream_bus_id,
  input  wire logic [7:0]          last_bus_id,
  // hub link
  output logic                     hub_valid,
  output cfar_pkg::cfar_cyc_s      hub_cyc,
  input  wire logic                hub_done,
  input  wire logic [31:0]         hub_rdata,
  input  wire logic                hub_mabort,
  // graphics-port bus
  output logic                     gp_valid,
  output cfar_pkg::cfar_cyc_s      gp_cyc,
  input  wire logic                gp_done,
  input  wire logic [31:0]         gp_rdata,
  input  wire logic                gp_mabort,
  output logic                     bridge_mabort,
  // internal configuration registers of devices 0..2
  output logic                     int_valid,
  output cfar_pkg::cfar_int_s      int_req,
  input  wire logic                int_done,
  input  wire logic [31:0]         int_rdata,
  // pointer enable bit
  output logic                     config_access_enable
);
  import cfar_pkg::*;

  typedef enum logic [1:0] {
    S_IDLE,
    S_INT,
    S_GP,
    S_HUB
  } cfar_state_e;

  typedef enum logic [1:0] {
    CL_PTR,
    CL_CFG,
    CL_PASS
  } cfar_class_e;

  cfar_state_e  state_r;
  cfar_state_e  state_nxt;
  cfar_class_e  cls;
  cfar_route_e  route;
  cfar_kind_e   kind;
  logic [31:0]  cyc_addr;
  logic [31:0]  ptr_r;
  logic         take;
  logic         ptr_hit;
  logic         data_hit;
  logic [13:0]  io_word;
  logic         immediate;
  logic         fin;
  logic [31:0]  fin_data;

  // answer registers toward the host
  logic         host_busy_r;
  logic         host_done_r;
  logic [31:0]  host_rdata_r;

  // downstream request registers
  logic         hub_valid_r;
  cfar_cyc_s    hub_cyc_r;
  logic         gp_valid_r;
  cfar_cyc_s    gp_cyc_r;
  logic         int_valid_r;
  cfar_int_s    int_req_r;
  logic         bridge_mabort_r;

  // one strobe per target to launch a cycle and one to end it
  logic         go_int;
  logic         go_gp;
  logic         go_hub;
  logic         end_int;
  logic         end_gp;
  logic         end_hub;

  cfar_decode u_decode (
    .ptr      (ptr_r),
    .sec_bus  (downstream_bus_id),
    .sub_bus  (last_bus_id),
    .route    (route),
    .kind     (kind),
    .cyc_addr (cyc_addr)
  );

  // request classification
  always_comb begin
    take     = host_valid && (state_r == S_IDLE);
    io_word  = cfar_io_word(host_req.addr);
    ptr_hit  = (io_word == cfar_io_word(CFAR_PTR_IO_ADDR))
               && (host_req.be == CFAR_BE_DWORD);
    data_hit = io_word == cfar_io_word(CFAR_DATA_IO_ADDR);
    if (ptr_hit) begin
      cls = CL_PTR;
    end else if (data_hit && ptr_r[CFAR_EN_BIT]) begin
      cls = CL_CFG;
    end else begin
      cls = CL_PASS;
    end
    immediate = take && ((cls == CL_PTR)
                || ((cls == CL_CFG) && (route == CFAR_RT_INT_ABORT)));
  end

  // state sequencing
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      S_IDLE: begin
        if (take) begin
          unique case (cls)
            CL_PTR: begin
              state_nxt = S_IDLE;
            end
            CL_CFG: begin
              unique case (route)
                CFAR_RT_INTERNAL:  state_nxt = S_INT;
                CFAR_RT_INT_ABORT: state_nxt = S_IDLE;
                CFAR_RT_GP:        state_nxt = S_GP;
                CFAR_RT_HUB:       state_nxt = S_HUB;
              endcase
            end
            CL_PASS: begin
              state_nxt = S_HUB;
            end
          endcase
        end
      end
      S_INT: begin
        if (int_done) begin
          state_nxt = S_IDLE;
        end
      end
      S_GP: begin
        if (gp_done) begin
          state_nxt = S_IDLE;
        end
      end
      S_HUB: begin
        if (hub_done) begin
          state_nxt = S_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= S_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // completion of a downstream cycle
  always_comb begin
    fin      = 1'b0;
    fin_data = CFAR_ABORT_DATA;
    unique case (state_r)
      S_IDLE: begin
        fin = 1'b0;
      end
      S_INT: begin
        fin      = int_done;
        fin_data = int_rdata;
      end
      S_GP: begin
        fin      = gp_done;
        fin_data = gp_mabort ? CFAR_ABORT_DATA : gp_rdata;
      end
      S_HUB: begin
        fin      = hub_done;
        fin_data = hub_mabort ? CFAR_ABORT_DATA : hub_rdata;
      end
    endcase
  end

  // pointer register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ptr_r <= CFAR_PTR_RESET;
    end else if (take && (cls == CL_PTR) && host_req.wr) begin
      ptr_r <= host_req.wdata & CFAR_PTR_WMASK;
    end
  end

  // launch and completion strobes per target
  always_comb begin
    go_int  = take && (state_nxt == S_INT);
    go_gp   = take && (state_nxt == S_GP);
    go_hub  = take && (state_nxt == S_HUB);
    end_int = (state_r == S_INT) && int_done;
    end_gp  = (state_r == S_GP) && gp_done;
    end_hub = (state_r == S_HUB) && hub_done;
  end

  // busy while a downstream cycle is outstanding
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      host_busy_r <= 1'b0;
    end else begin
      host_busy_r <= state_nxt != S_IDLE;
    end
  end

  // one-cycle answer strobe
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      host_done_r <= 1'b0;
    end else begin
      host_done_r <= immediate || fin;
    end
  end

  // answer data, held until the next answer
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      host_rdata_r <= '0;
    end else if (immediate) begin
      // pointer writes answer zero
      if (cls == CL_PTR) begin
        host_rdata_r <= host_req.wr ? '0 : ptr_r;
      end else begin
        host_rdata_r <= CFAR_ABORT_DATA;
      end
    end else if (fin) begin
      host_rdata_r <= fin_data;
    end
  end

  // hub link request strobe
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      hub_valid_r <= 1'b0;
    end else if (go_hub) begin
      hub_valid_r <= 1'b1;
    end else if (end_hub) begin
      hub_valid_r <= 1'b0;
    end
  end

  // hub link request fields, held while the cycle is outstanding
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      hub_cyc_r <= '0;
    end else if (go_hub) begin
      hub_cyc_r.wr    <= host_req.wr;
      hub_cyc_r.be    <= host_req.be;
      hub_cyc_r.wdata <= host_req.wdata;
      // pass-through I/O keeps the host address as is
      if (cls == CL_PASS) begin
        hub_cyc_r.kind <= CFAR_CYC_IO;
        hub_cyc_r.addr <= {16'h0000, host_req.addr};
      end else begin
        hub_cyc_r.kind <= kind;
        hub_cyc_r.addr <= cyc_addr;
      end
    end
  end

  // graphics-port request strobe
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      gp_valid_r <= 1'b0;
    end else if (go_gp) begin
      gp_valid_r <= 1'b1;
    end else if (end_gp) begin
      gp_valid_r <= 1'b0;
    end
  end

  // graphics-port request fields
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      gp_cyc_r <= '0;
    end else if (go_gp) begin
      gp_cyc_r.wr    <= host_req.wr;
      gp_cyc_r.be    <= host_req.be;
      gp_cyc_r.wdata <= host_req.wdata;
      gp_cyc_r.kind  <= kind;
      gp_cyc_r.addr  <= cyc_addr;
    end
  end

  // master abort on the graphics port goes to the bridge status
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      bridge_mabort_r <= 1'b0;
    end else begin
      bridge_mabort_r <= end_gp && gp_mabort;
    end
  end

  // internal register request strobe
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      int_valid_r <= 1'b0;
    end else if (go_int) begin
      int_valid_r <= 1'b1;
    end else if (end_int) begin
      int_valid_r <= 1'b0;
    end
  end

  // internal register request fields
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      int_req_r <= '0;
    end else if (go_int) begin
      int_req_r.wr    <= host_req.wr;
      // only devices 0..2 route here, two bits suffice
      int_req_r.dev   <= ptr_r[CFAR_DEV_LSB +: 2];
      int_req_r.regn  <= cfar_reg(ptr_r);
      int_req_r.be    <= host_req.be;
      int_req_r.wdata <= host_req.wdata;
    end
  end

  assign host_busy            = host_busy_r;
  assign host_done            = host_done_r;
  assign host_rdata           = host_rdata_r;
  assign hub_valid            = hub_valid_r;
  assign hub_cyc              = hub_cyc_r;
  assign gp_valid             = gp_valid_r;
  assign gp_cyc               = gp_cyc_r;
  assign bridge_mabort        = bridge_mabort_r;
  assign int_valid            = int_valid_r;
  assign int_req              = int_req_r;
  assign config_access_enable = ptr_r[CFAR_EN_BIT];

endmodule
`default_nettype wire
